// File: rtl/tpdrm_pkg.sv
package tpdrm_pkg;

  // ------------------------------------------------------------
  // Serial target address and input filtering
  // ------------------------------------------------------------
  localparam logic [6:0] TPDRM_TGT_ADDR     = 7'h22;
  localparam int         TPDRM_CLK_PERIOD_PS = 20000;
  localparam int         TPDRM_SPIKE_MAX_PS  = 50000;
  // A spike this wide can cover ceil(max/period) samples, so one more is needed
  localparam int         TPDRM_FILT_CYC      =
    (TPDRM_SPIKE_MAX_PS + TPDRM_CLK_PERIOD_PS - 1) / TPDRM_CLK_PERIOD_PS + 1;

  // ------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------
  localparam logic [7:0] TPDRM_A_IDENTITY  = 8'h01;
  localparam logic [7:0] TPDRM_A_CC_SW     = 8'h02;
  localparam logic [7:0] TPDRM_A_ACK_HDR   = 8'h03;
  localparam logic [7:0] TPDRM_A_MEASURE   = 8'h04;
  localparam logic [7:0] TPDRM_A_SLICER    = 8'h05;
  localparam logic [7:0] TPDRM_A_TX_CMD    = 8'h06;
  localparam logic [7:0] TPDRM_A_RX_SOP    = 8'h07;
  localparam logic [7:0] TPDRM_A_TOGGLE    = 8'h08;
  localparam logic [7:0] TPDRM_A_RETRY     = 8'h09;
  localparam logic [7:0] TPDRM_A_PRI_MASK  = 8'h0a;
  localparam logic [7:0] TPDRM_A_POWER     = 8'h0b;
  localparam logic [7:0] TPDRM_A_SOFT_RST  = 8'h0c;
  localparam logic [7:0] TPDRM_A_OCP       = 8'h0d;
  localparam logic [7:0] TPDRM_A_PDE_MASK  = 8'h0e;
  localparam logic [7:0] TPDRM_A_ACK_MASK  = 8'h0f;
  localparam logic [7:0] TPDRM_A_TOG_EXIT  = 8'h10;
  localparam logic [7:0] TPDRM_A_PDE_STAT  = 8'h3c;
  localparam logic [7:0] TPDRM_A_TOG_STAT  = 8'h3d;
  localparam logic [7:0] TPDRM_A_PDE_FLAGS = 8'h3e;
  localparam logic [7:0] TPDRM_A_ACK_FLAGS = 8'h3f;
  localparam logic [7:0] TPDRM_A_LINE_STAT = 8'h40;
  localparam logic [7:0] TPDRM_A_QUEUE_ST  = 8'h41;
  localparam logic [7:0] TPDRM_A_PRI_FLAGS = 8'h42;
  localparam logic [7:0] TPDRM_A_QUEUE     = 8'h43;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] TPDRM_R_CC_SW    = 8'h03;
  localparam logic [7:0] TPDRM_R_ACK_HDR  = 8'h20;
  localparam logic [7:0] TPDRM_R_MEASURE  = 8'h31;
  localparam logic [7:0] TPDRM_R_SLICER   = 8'h60;
  localparam logic [7:0] TPDRM_R_TX_CMD   = 8'h24;
  localparam logic [7:0] TPDRM_R_RX_SOP   = 8'h00;
  localparam logic [7:0] TPDRM_R_TOGGLE   = 8'h02;
  localparam logic [7:0] TPDRM_R_RETRY    = 8'h06;
  localparam logic [7:0] TPDRM_R_MASK     = 8'h00;
  localparam logic [7:0] TPDRM_R_POWER    = 8'h01;
  localparam logic [7:0] TPDRM_R_OCP      = 8'h0f;
  localparam logic [7:0] TPDRM_R_TOG_EXIT = 8'h00;
  localparam logic [7:0] TPDRM_R_STATUS   = 8'h00;
  localparam logic [7:0] TPDRM_R_QUEUE_ST = 8'h28;
  localparam logic [7:0] TPDRM_R_FLAGS    = 8'h00;

  // ------------------------------------------------------------
  // Command bit positions
  // ------------------------------------------------------------
  localparam int TPDRM_B_TX_START  = 0;
  localparam int TPDRM_B_TX_FLUSH  = 6;
  localparam int TPDRM_B_RX_FLUSH  = 2;
  localparam int TPDRM_B_DEV_RST   = 0;
  localparam int TPDRM_B_PD_RST    = 1;
  localparam logic [7:0] TPDRM_TX_CMD_SC = 8'h41;
  localparam logic [7:0] TPDRM_RX_SOP_SC = 8'h04;

  typedef enum logic [2:0] {
    TPDRM_ST_IDLE,
    TPDRM_ST_RX,
    TPDRM_ST_ACK,
    TPDRM_ST_TX,
    TPDRM_ST_MACK
  } tpdrm_state_e;

  typedef enum logic [1:0] {
    TPDRM_K_ADDR,
    TPDRM_K_PTR,
    TPDRM_K_DATA
  } tpdrm_kind_e;

endpackage : tpdrm_pkg

// File: rtl/tpdrm_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Answer target address 0100010, bit eight selects direction
// - Accept serial clock up to 1000 kHz
// - Filter out bus spikes up to 50 ns
// - Queue port pushes writes, pops reads, pointer holds
// - Interrupt flag registers clear when read
// - Reset command bits act once, self clear
// - Control command bits self clear; resets 0x24, 0x00
// - Queue status reads 0x28 after reset
// - Mask bits pair with same flag position
// - Identity register read-only, version and revision fields
module tpdrm_regs
  import tpdrm_pkg::*;
#(
  parameter logic [3:0] VERSION_FIELD  = 4'h1,  // Arbitrary value
  parameter logic [3:0] REVISION_FIELD = 4'h0   // Arbitrary value
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // Serial bus pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  // Configuration to the core
  output logic [7:0]      o_cc_switch_ctrl,
  output logic [7:0]      o_ack_header_tx_ctrl,
  output logic [7:0]      o_measure,
  output logic [7:0]      o_slicer_threshold,
  output logic [7:0]      o_tx_command_ctrl,
  output logic [7:0]      o_rx_sop_ctrl,
  output logic [7:0]      o_toggle_ctrl,
  output logic [7:0]      o_retry_reset_ctrl,
  output logic [7:0]      o_power_enable,
  output logic [7:0]      o_overcurrent_limit,
  output logic [7:0]      o_toggle_exit_ctrl,
  output logic [7:0]      o_primary_irq_mask,
  output logic [7:0]      o_pd_event_irq_mask,
  output logic [7:0]      o_ack_sent_irq_mask,
  // Command pulses to the core
  output logic            o_tx_start,
  output logic            o_tx_flush,
  output logic            o_rx_flush,
  output logic            o_delivery_logic_reset,
  output logic            o_whole_device_reset,
  // Status from the core
  input  wire logic [7:0] i_pd_event_status,
  input  wire logic [7:0] i_toggle_sop_status,
  input  wire logic [7:0] i_line_status,
  input  wire logic [7:0] i_queue_fault_status,
  // Interrupt events from the core, one-cycle pulses
  input  wire logic [7:0] i_primary_irq_set,
  input  wire logic [7:0] i_pd_event_irq_set,
  input  wire logic [7:0] i_ack_sent_irq_set,
  // Queue port
  output logic            o_txq_push,
  output logic [7:0]      o_txq_data,
  output logic            o_rxq_pop,
  input  wire logic [7:0] i_rxq_data
);

  // ------------------------------------------------------------
  // Pin synchronisers and spike filters
  // ------------------------------------------------------------
  logic [1:0] pin_in;
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [1:0] filt_r;
  logic [1:0] filt_q_r;

  assign pin_in = {i_sda, i_scl};

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_filt
      logic [2:0] cnt_r;
      always_ff @(posedge i_clk or posedge i_reset)
      begin
        if (i_reset)
        begin
          sync1_r[g]  <= 1'b1;
          sync2_r[g]  <= 1'b1;
          filt_r[g]   <= 1'b1;
          filt_q_r[g] <= 1'b1;
          cnt_r       <= 3'h0;
        end
        else
        begin
          sync1_r[g]  <= pin_in[g];
          sync2_r[g]  <= sync1_r[g];
          filt_q_r[g] <= filt_r[g];
          // A level must hold for more samples than a spike can span
          if (sync2_r[g] == filt_r[g])
            cnt_r <= 3'h0;
          else if (cnt_r == 3'(TPDRM_FILT_CYC - 1))
          begin
            filt_r[g] <= sync2_r[g];
            cnt_r     <= 3'h0;
          end
          else
            cnt_r <= cnt_r + 3'h1;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Bus events
  // ------------------------------------------------------------
  wire scl_rise  = filt_r[0] & ~filt_q_r[0];
  wire scl_fall  = ~filt_r[0] & filt_q_r[0];
  wire scl_high  = filt_r[0] & filt_q_r[0];
  wire bus_start = scl_high & filt_q_r[1] & ~filt_r[1];
  wire bus_stop  = scl_high & ~filt_q_r[1] & filt_r[1];
  wire sda_in    = filt_r[1];

  // ------------------------------------------------------------
  // Serial target state
  // ------------------------------------------------------------
  tpdrm_state_e state_r;
  tpdrm_kind_e  kind_r;
  logic [3:0]   bitcnt_r;
  logic [7:0]   shift_r;
  logic [7:0]   ptr_r;
  logic         rd_r;
  logic         nack_r;

  logic [7:0] cc_sw_r, ack_hdr_r, measure_r, slicer_r, tx_cmd_r, rx_sop_r;
  logic [7:0] toggle_r, retry_r, power_r, ocp_r, tog_exit_r;
  logic [7:0] pri_mask_r, pde_mask_r, ack_mask_r;
  logic [7:0] pde_stat_r, tog_stat_r, line_stat_r, queue_st_r;
  logic [7:0] pri_flags_r, pde_flags_r, ack_flags_r;

  // Byte complete, and a write byte landing in the register file
  wire byte_done = (state_r == TPDRM_ST_RX) && scl_fall && (bitcnt_r == 4'h8);
  wire addr_hit  = (shift_r[7:1] == TPDRM_TGT_ADDR);
  wire wr_strobe = byte_done && (kind_r == TPDRM_K_DATA);
  // A read byte is fetched on leaving an address ack or a host ack
  wire rd_fetch  = scl_fall && !nack_r &&
                   (((state_r == TPDRM_ST_ACK) && (kind_r == TPDRM_K_ADDR) && rd_r) ||
                    (state_r == TPDRM_ST_MACK));
  wire on_queue  = (ptr_r == TPDRM_A_QUEUE);
  wire ptr_step  = (wr_strobe || rd_fetch) && !on_queue;

  function automatic logic wr_at(input logic [7:0] a);
    return wr_strobe && (ptr_r == a);
  endfunction : wr_at

  // ------------------------------------------------------------
  // Read selection
  // ------------------------------------------------------------
  logic [7:0] rd_data;
  always_comb
  begin
    case (ptr_r)
      TPDRM_A_IDENTITY:  rd_data = {VERSION_FIELD, REVISION_FIELD};
      TPDRM_A_CC_SW:     rd_data = cc_sw_r;
      TPDRM_A_ACK_HDR:   rd_data = ack_hdr_r;
      TPDRM_A_MEASURE:   rd_data = measure_r;
      TPDRM_A_SLICER:    rd_data = slicer_r;
      TPDRM_A_TX_CMD:    rd_data = tx_cmd_r;
      TPDRM_A_RX_SOP:    rd_data = rx_sop_r;
      TPDRM_A_TOGGLE:    rd_data = toggle_r;
      TPDRM_A_RETRY:     rd_data = retry_r;
      TPDRM_A_PRI_MASK:  rd_data = pri_mask_r;
      TPDRM_A_POWER:     rd_data = power_r;
      TPDRM_A_OCP:       rd_data = ocp_r;
      TPDRM_A_PDE_MASK:  rd_data = pde_mask_r;
      TPDRM_A_ACK_MASK:  rd_data = ack_mask_r;
      TPDRM_A_TOG_EXIT:  rd_data = tog_exit_r;
      TPDRM_A_PDE_STAT:  rd_data = pde_stat_r;
      TPDRM_A_TOG_STAT:  rd_data = tog_stat_r;
      TPDRM_A_PDE_FLAGS: rd_data = pde_flags_r;
      TPDRM_A_ACK_FLAGS: rd_data = ack_flags_r;
      TPDRM_A_LINE_STAT: rd_data = line_stat_r;
      TPDRM_A_QUEUE_ST:  rd_data = queue_st_r;
      TPDRM_A_PRI_FLAGS: rd_data = pri_flags_r;
      TPDRM_A_QUEUE:     rd_data = i_rxq_data;
      default:           rd_data = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // Protocol engine
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_r  <= TPDRM_ST_IDLE;
      kind_r   <= TPDRM_K_ADDR;
      bitcnt_r <= 4'h0;
      shift_r  <= 8'h00;
      ptr_r    <= 8'h00;
      rd_r     <= 1'b0;
      nack_r   <= 1'b0;
      o_sda_oe <= 1'b0;
    end
    else if (bus_stop)
    begin
      state_r  <= TPDRM_ST_IDLE;
      o_sda_oe <= 1'b0;
    end
    else if (bus_start)
    begin
      // Repeated start keeps the pointer for a following read
      state_r  <= TPDRM_ST_RX;
      kind_r   <= TPDRM_K_ADDR;
      bitcnt_r <= 4'h0;
      nack_r   <= 1'b0;
      o_sda_oe <= 1'b0;
    end
    else
    begin
      if (ptr_step)
        ptr_r <= ptr_r + 8'h01;
      case (state_r)
        TPDRM_ST_RX:
        begin
          if (scl_rise)
          begin
            shift_r  <= {shift_r[6:0], sda_in};
            bitcnt_r <= bitcnt_r + 4'h1;
          end
          else if (byte_done)
          begin
            if (kind_r == TPDRM_K_ADDR && !addr_hit)
              state_r <= TPDRM_ST_IDLE;
            else
            begin
              state_r  <= TPDRM_ST_ACK;
              o_sda_oe <= 1'b1;
              if (kind_r == TPDRM_K_ADDR)
                rd_r <= shift_r[0];
              if (kind_r == TPDRM_K_PTR)
                ptr_r <= shift_r;
            end
          end
        end
        TPDRM_ST_ACK:
        begin
          if (scl_fall)
          begin
            bitcnt_r <= 4'h0;
            if (rd_fetch)
            begin
              state_r  <= TPDRM_ST_TX;
              shift_r  <= rd_data;
              o_sda_oe <= ~rd_data[7];
            end
            else
            begin
              state_r  <= TPDRM_ST_RX;
              kind_r   <= (kind_r == TPDRM_K_ADDR) ? TPDRM_K_PTR : TPDRM_K_DATA;
              o_sda_oe <= 1'b0;
            end
          end
        end
        TPDRM_ST_TX:
        begin
          if (scl_fall)
          begin
            if (bitcnt_r == 4'h7)
            begin
              state_r  <= TPDRM_ST_MACK;
              o_sda_oe <= 1'b0;
            end
            else
            begin
              shift_r  <= {shift_r[6:0], 1'b0};
              o_sda_oe <= ~shift_r[6];
              bitcnt_r <= bitcnt_r + 4'h1;
            end
          end
        end
        TPDRM_ST_MACK:
        begin
          if (scl_rise)
            nack_r <= sda_in;
          else if (scl_fall)
          begin
            bitcnt_r <= 4'h0;
            if (rd_fetch)
            begin
              state_r  <= TPDRM_ST_TX;
              shift_r  <= rd_data;
              o_sda_oe <= ~rd_data[7];
            end
            else
              state_r <= TPDRM_ST_IDLE;
          end
        end
        default:
          o_sda_oe <= 1'b0;
      endcase
    end
  end

  // Open drain: the pin is only ever pulled low
  assign o_sda = 1'b0;

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  // Command pulse is a flop output, so it is a clean reset source
  wire regs_rst = i_reset | o_whole_device_reset;
  wire rd_pri   = rd_fetch && (ptr_r == TPDRM_A_PRI_FLAGS);
  wire rd_pde   = rd_fetch && (ptr_r == TPDRM_A_PDE_FLAGS);
  wire rd_ack   = rd_fetch && (ptr_r == TPDRM_A_ACK_FLAGS);

  always_ff @(posedge i_clk or posedge regs_rst)
  begin
    if (regs_rst)
    begin
      cc_sw_r     <= TPDRM_R_CC_SW;
      ack_hdr_r   <= TPDRM_R_ACK_HDR;
      measure_r   <= TPDRM_R_MEASURE;
      slicer_r    <= TPDRM_R_SLICER;
      tx_cmd_r    <= TPDRM_R_TX_CMD;
      rx_sop_r    <= TPDRM_R_RX_SOP;
      toggle_r    <= TPDRM_R_TOGGLE;
      retry_r     <= TPDRM_R_RETRY;
      power_r     <= TPDRM_R_POWER;
      ocp_r       <= TPDRM_R_OCP;
      tog_exit_r  <= TPDRM_R_TOG_EXIT;
      pri_mask_r  <= TPDRM_R_MASK;
      pde_mask_r  <= TPDRM_R_MASK;
      ack_mask_r  <= TPDRM_R_MASK;
      pde_stat_r  <= TPDRM_R_STATUS;
      tog_stat_r  <= TPDRM_R_STATUS;
      line_stat_r <= TPDRM_R_STATUS;
      queue_st_r  <= TPDRM_R_QUEUE_ST;
      pri_flags_r <= TPDRM_R_FLAGS;
      pde_flags_r <= TPDRM_R_FLAGS;
      ack_flags_r <= TPDRM_R_FLAGS;
    end
    else
    begin
      if (wr_at(TPDRM_A_CC_SW))    cc_sw_r    <= shift_r;
      if (wr_at(TPDRM_A_ACK_HDR))  ack_hdr_r  <= shift_r;
      if (wr_at(TPDRM_A_MEASURE))  measure_r  <= shift_r;
      if (wr_at(TPDRM_A_SLICER))   slicer_r   <= shift_r;
      if (wr_at(TPDRM_A_TX_CMD))   tx_cmd_r   <= shift_r & ~TPDRM_TX_CMD_SC;
      if (wr_at(TPDRM_A_RX_SOP))   rx_sop_r   <= shift_r & ~TPDRM_RX_SOP_SC;
      if (wr_at(TPDRM_A_TOGGLE))   toggle_r   <= shift_r;
      if (wr_at(TPDRM_A_RETRY))    retry_r    <= shift_r;
      if (wr_at(TPDRM_A_POWER))    power_r    <= shift_r;
      if (wr_at(TPDRM_A_OCP))      ocp_r      <= shift_r;
      if (wr_at(TPDRM_A_TOG_EXIT)) tog_exit_r <= shift_r;
      if (wr_at(TPDRM_A_PRI_MASK)) pri_mask_r <= shift_r;
      if (wr_at(TPDRM_A_PDE_MASK)) pde_mask_r <= shift_r;
      if (wr_at(TPDRM_A_ACK_MASK)) ack_mask_r <= shift_r;
      pde_stat_r  <= i_pd_event_status;
      tog_stat_r  <= i_toggle_sop_status;
      line_stat_r <= i_line_status;
      queue_st_r  <= i_queue_fault_status;
      // An event in the cycle of the clearing read survives it
      pri_flags_r <= (rd_pri ? 8'h00 : pri_flags_r) | i_primary_irq_set;
      pde_flags_r <= (rd_pde ? 8'h00 : pde_flags_r) | i_pd_event_irq_set;
      ack_flags_r <= (rd_ack ? 8'h00 : ack_flags_r) | i_ack_sent_irq_set;
    end
  end

  // ------------------------------------------------------------
  // Command pulses and queue strobes
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_tx_start             <= 1'b0;
      o_tx_flush             <= 1'b0;
      o_rx_flush             <= 1'b0;
      o_delivery_logic_reset <= 1'b0;
      o_whole_device_reset   <= 1'b0;
      o_txq_push             <= 1'b0;
      o_txq_data             <= 8'h00;
      o_rxq_pop              <= 1'b0;
    end
    else
    begin
      o_tx_start             <= wr_at(TPDRM_A_TX_CMD) && shift_r[TPDRM_B_TX_START];
      o_tx_flush             <= wr_at(TPDRM_A_TX_CMD) && shift_r[TPDRM_B_TX_FLUSH];
      o_rx_flush             <= wr_at(TPDRM_A_RX_SOP) && shift_r[TPDRM_B_RX_FLUSH];
      o_delivery_logic_reset <= wr_at(TPDRM_A_SOFT_RST) && shift_r[TPDRM_B_PD_RST];
      o_whole_device_reset   <= wr_at(TPDRM_A_SOFT_RST) && shift_r[TPDRM_B_DEV_RST];
      o_txq_push             <= wr_at(TPDRM_A_QUEUE);
      if (wr_at(TPDRM_A_QUEUE))
        o_txq_data <= shift_r;
      o_rxq_pop              <= rd_fetch && on_queue;
    end
  end

  // ------------------------------------------------------------
  // Configuration outputs
  // ------------------------------------------------------------
  assign o_cc_switch_ctrl     = cc_sw_r;
  assign o_ack_header_tx_ctrl = ack_hdr_r;
  assign o_measure            = measure_r;
  assign o_slicer_threshold   = slicer_r;
  assign o_tx_command_ctrl    = tx_cmd_r;
  assign o_rx_sop_ctrl        = rx_sop_r;
  assign o_toggle_ctrl        = toggle_r;
  assign o_retry_reset_ctrl   = retry_r;
  assign o_power_enable       = power_r;
  assign o_overcurrent_limit  = ocp_r;
  assign o_toggle_exit_ctrl   = tog_exit_r;
  assign o_primary_irq_mask   = pri_mask_r;
  assign o_pd_event_irq_mask  = pde_mask_r;
  assign o_ack_sent_irq_mask  = ack_mask_r;

endmodule : tpdrm_regs

`default_nettype wire

// File: testbench/tpdrm_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module tpdrm_regs_assertions (
  // Clock, reset and bus
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic       i_scl,
  input wire logic       o_sda_oe,
  // Registers and strobes
  input wire logic [7:0] o_cc_switch_ctrl,
  input wire logic [7:0] o_tx_command_ctrl,
  input wire logic [7:0] o_rx_sop_ctrl,
  input wire logic [7:0] o_primary_irq_mask,
  input wire logic       o_tx_start,
  input wire logic       o_tx_flush,
  input wire logic       o_rx_flush,
  input wire logic       o_delivery_logic_reset,
  input wire logic       o_whole_device_reset,
  input wire logic       o_txq_push,
  input wire logic [7:0] o_txq_data,
  input wire logic       o_rxq_pop
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_start_pulse: assert property (o_tx_start |=> !o_tx_start)
    else $error("start pulse too long");
  a_flush_pulse: assert property (o_tx_flush || o_rx_flush |=> !o_tx_flush && !o_rx_flush)
    else $error("flush pulse too long");
  a_cmd_bits_zero: assert property (!o_tx_command_ctrl[0] && !o_tx_command_ctrl[6] && !o_rx_sop_ctrl[2])
    else $error("command bit did not clear");
  a_delivery_logic_reset_once: assert property (o_delivery_logic_reset |=> !o_delivery_logic_reset)
    else $error("delivery reset pulse too long");
  a_dev_reset_clears: assert property (o_whole_device_reset |=> !o_whole_device_reset && o_cc_switch_ctrl == 8'h03 && o_primary_irq_mask == 8'h00)
    else $error("device reset left registers set");
  a_push_single: assert property (o_txq_push |=> !o_txq_push [*8])
    else $error("push repeated");
  a_push_data_held: assert property (!o_txq_push |-> $stable(o_txq_data))
    else $error("queue data moved without push");
  a_pop_spacing: assert property ($rose(o_rxq_pop) |=> !o_rxq_pop [*8])
    else $error("pop repeated");
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data line changed while clock high");
endmodule : tpdrm_regs_assertions

bind tpdrm_regs tpdrm_regs_assertions i_tpdrm_regs_assertions (
  .i_clk, .i_reset, .i_scl, .o_sda_oe, .o_cc_switch_ctrl, .o_tx_command_ctrl,
  .o_rx_sop_ctrl, .o_primary_irq_mask, .o_tx_start, .o_tx_flush, .o_rx_flush,
  .o_delivery_logic_reset, .o_whole_device_reset, .o_txq_push, .o_txq_data, .o_rxq_pop
);

`default_nettype wire

// File: testbench/tpdrm_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Bus master at the top permitted rate; never writes undefined places
module tpdrm_host_model #(
  parameter int T_LOW  = 600,
  parameter int T_HIGH = 400
) (
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  logic spike = 1'b0;

  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // Sampling at the end of high leaves the device its full answer time
  task automatic bit_io(input logic d, output logic q);
    o_scl = 1'b0;
    #(T_LOW / 4) o_sda = d;
    if (spike)
    begin
      // Spike placed well clear of the device's data change after the fall
      #(T_LOW / 2) o_scl = 1'b1;
      #50 o_scl = 1'b0;
      #(T_LOW / 4 - 50);
    end
    else
      #(T_LOW * 3 / 4);
    o_scl = 1'b1;
    #(T_HIGH) q = i_sda;
  endtask : bit_io

  task automatic start();
    o_scl = 1'b0;
    #(T_LOW / 2) o_sda = 1'b1;
    #(T_LOW / 2) o_scl = 1'b1;
    #(T_HIGH) o_sda = 1'b0;
    #(T_HIGH);
  endtask : start

  task automatic stop();
    o_scl = 1'b0;
    #(T_LOW / 2) o_sda = 1'b0;
    #(T_LOW / 2) o_scl = 1'b1;
    #(T_HIGH) o_sda = 1'b1;
    #(2 * T_HIGH);
  endtask : stop

  task automatic send(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], q);
    bit_io(1'b1, q);
    ack = ~q;
  endtask : send

  task automatic recv(input logic last, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(last, q);
  endtask : recv

  task automatic xfer_wr(input logic [6:0] dev, input logic [7:0] ptr,
                         input logic [7:0] d[$], output logic ok);
    logic a;
    start();
    send({dev, 1'b0}, ok);
    if (ok)
    begin
      send(ptr, a);
      foreach (d[i])
        send(d[i], a);
    end
    stop();
  endtask : xfer_wr

  task automatic xfer_rd(input logic [7:0] ptr, input int n, output logic [7:0] d[$]);
    logic       a;
    logic [7:0] b;
    d = {};
    start();
    send({7'h22, 1'b0}, a);
    send(ptr, a);
    start();
    send({7'h22, 1'b1}, a);
    for (int i = 0; i < n; i++)
    begin
      recv(i == n - 1, b);
      d.push_back(b);
    end
    stop();
  endtask : xfer_rd
endmodule : tpdrm_host_model

`default_nettype wire

// File: testbench/test_tpdrm_regs.sv
`timescale 1ns/1ps
`default_nettype none

module test_tpdrm_regs;
  import tpdrm_pkg::*;

  logic       clk = 1'b0;
  logic       reset = 1'b1;
  wire  logic scl, host_sda, dev_sda, dev_oe, sda;
  wire  logic [7:0] cc, txc, rxc, m0, m1, m2, txd, ms;
  wire  logic [6:0] pl;
  logic [7:0] st [4] = '{8'h1c, 8'h2d, 8'h40, 8'h28};
  logic [7:0] irq [3] = '{default: 8'h00};
  logic [7:0] fadr [3] = '{8'h42, 8'h3e, 8'h3f};
  logic [7:0] fpat [3] = '{8'ha5, 8'h5a, 8'h01};
  logic [7:0] rxq = 8'h70;
  logic [7:0] pushed[$];
  logic       ok;
  int         n_fail = 0;
  int         checks_done = 0;
  int         cnt [7] = '{default: 0};

  always #10 clk = ~clk;
  // Released line floats high through the pull-up
  assign sda = host_sda & (dev_oe ? dev_sda : 1'b1);

  tpdrm_host_model i_tpdrm_host_model (.i_sda(sda), .o_scl(scl), .o_sda(host_sda));

  tpdrm_regs #(.VERSION_FIELD(4'h5), .REVISION_FIELD(4'h3)) i_tpdrm_regs (  // Arbitrary identity
    .i_clk(clk), .i_reset(reset), .i_scl(scl), .i_sda(sda), .o_sda(dev_sda),
    .o_sda_oe(dev_oe), .o_cc_switch_ctrl(cc), .o_ack_header_tx_ctrl(), .o_measure(ms),
    .o_slicer_threshold(), .o_tx_command_ctrl(txc), .o_rx_sop_ctrl(rxc),
    .o_toggle_ctrl(), .o_retry_reset_ctrl(), .o_power_enable(), .o_overcurrent_limit(),
    .o_toggle_exit_ctrl(), .o_primary_irq_mask(m0), .o_pd_event_irq_mask(m1),
    .o_ack_sent_irq_mask(m2), .o_tx_start(pl[0]), .o_tx_flush(pl[1]), .o_rx_flush(pl[2]),
    .o_delivery_logic_reset(pl[3]), .o_whole_device_reset(pl[4]),
    .i_pd_event_status(st[0]), .i_toggle_sop_status(st[1]), .i_line_status(st[2]),
    .i_queue_fault_status(st[3]), .i_primary_irq_set(irq[0]), .i_pd_event_irq_set(irq[1]),
    .i_ack_sent_irq_set(irq[2]), .o_txq_push(pl[5]), .o_txq_data(txd), .o_rxq_pop(pl[6]),
    .i_rxq_data(rxq)
  );

  always @(posedge clk)
  begin
    for (int k = 0; k < 7; k++)
      cnt[k] += int'(pl[k]);
    if (pl[5])
      pushed.push_back(txd);
    if (pl[6])
      rxq <= rxq + 8'h01;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
    logic a;
    i_tpdrm_host_model.xfer_wr(7'h22, ptr, d, a);
    chk({7'h00, a}, 8'h01, "write ack");
  endtask : wr

  task automatic rd(input logic [7:0] ptr, input logic [7:0] e[$], input string what);
    logic [7:0] got[$];
    i_tpdrm_host_model.xfer_rd(ptr, e.size(), got);
    foreach (e[k])
      chk(got[k], e[k], what);
    $display("Test %s done", what);
  endtask : rd

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  initial
  begin
    #2ms;
    n_fail++;
    $display("MISMATCH at %0t: run timed out", $time);
    conclude();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (10) @(posedge clk);
    rd(8'h02, {8'h03, 8'h20, 8'h31, 8'h60, 8'h24, 8'h00, 8'h02, 8'h06, 8'h00, 8'h01}, "reset");
    rd(8'h0d, {8'h0f, 8'h00, 8'h00, 8'h00}, "reset tail");
    wr(8'h01, {8'hff});
    rd(8'h01, {8'h53}, "identity");
    rd(8'h3c, {8'h1c, 8'h2d, 8'h00, 8'h00, 8'h40, 8'h28, 8'h00}, "status");
    wr(8'h02, {8'h5a, 8'ha5, 8'h3c, 8'hc3});
    rd(8'h02, {8'h5a, 8'ha5, 8'h3c, 8'hc3}, "burst");
    wr(8'h0a, {8'h81});
    wr(8'h0e, {8'h42, 8'h01});
    chk(m0, 8'h81, "mask a");
    chk(m1, 8'h42, "mask b");
    chk(m2, 8'h01, "mask c");
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk);
      irq[k] <= fpat[k];
      @(posedge clk);
      irq[k] <= 8'h00;
      rd(fadr[k], {fpat[k]}, "flag set");
      rd(fadr[k], {8'h00}, "flag clear");
    end
    wr(8'h06, {8'hff});
    chk(txc, 8'hbe, "tx control");
    rd(8'h06, {8'hbe}, "tx readback");
    wr(8'h07, {8'h36});
    rd(8'h07, {8'h32}, "rx readback");
    wr(8'h06, {8'h24});
    chk(8'(cnt[0]), 8'h01, "start count");
    chk(8'(cnt[1]), 8'h01, "tx flush count");
    chk(8'(cnt[2]), 8'h01, "rx flush count");
    wr(8'h0c, {8'h02});
    chk(8'(cnt[3]), 8'h01, "delivery reset count");
    chk(8'(cnt[4]), 8'h00, "device reset early");
    chk(cc, 8'h5a, "kept register");
    wr(8'h0c, {8'h01});
    chk(8'(cnt[4]), 8'h01, "device reset count");
    chk(cc, 8'h03, "register reset");
    chk(m0, 8'h00, "mask reset");
    wr(8'h43, {8'h11, 8'h22, 8'h33});
    chk(8'(cnt[5]), 8'h03, "push count");
    foreach (pushed[k])
      chk(pushed[k], 8'h11 * 8'(k + 1), "pushed byte");
    rd(8'h43, {8'h70, 8'h71}, "queue pop");
    chk(8'(cnt[6]), 8'h02, "pop count");
    i_tpdrm_host_model.xfer_wr(7'h23, 8'h02, {8'h99}, ok);
    chk({7'h00, ok}, 8'h00, "foreign address");
    rd(8'h02, {8'h03}, "foreign ignored");
    rd(8'h20, {8'h00}, "unmapped");
    i_tpdrm_host_model.spike = 1'b1;
    wr(8'h04, {8'h96});
    rd(8'h04, {8'h96}, "spikes");
    chk(ms, 8'h96, "measure output");
    conclude();
  end
endmodule : test_tpdrm_regs

`default_nettype wire
